// ==== rtl/swg_defs.svh ====
// Purpose: Shared constants for the sweep generator pin control block
// Assumes: Included by bare name from package and both ends
// Notes: Offsets, field positions, reset values and timing counts
`ifndef SWG_DEFS_SVH
`define SWG_DEFS_SVH

// ***************************************************************
// Serial word layout
// ***************************************************************
`define SWG_WORD_BITS 16
`define SWG_ADDR_HI 15
`define SWG_ADDR_LO 12
`define SWG_DATA_HI 11
`define SWG_LAST_BIT 4'hF

// ***************************************************************
// Device register addresses (serial address field)
// ***************************************************************
`define SWG_ADDR_CTRL 4'h0
`define SWG_ADDR_FSTART 4'h1
`define SWG_ADDR_FDELTA 4'h2
`define SWG_ADDR_NINCR 4'h3
`define SWG_ADDR_TINT 4'h4
`define SWG_ADDR_TBURST 4'h5

// ***************************************************************
// Control register fields
// ***************************************************************
`define SWG_CTRL_EXT_INC 0
`define SWG_CTRL_SRC_SEL 1
`define SWG_CTRL_STAT_OE 2
`define SWG_CTRL_SIGN_OE 3
`define SWG_CTRL_MODE 7

// ***************************************************************
// Device reset values and timer limit
// ***************************************************************
`define SWG_RST_CTRL 12'h000
`define SWG_RST_FSTART 12'h100
`define SWG_RST_FDELTA 12'h010
`define SWG_RST_NINCR 12'h004
`define SWG_RST_TINT 12'h020
`define SWG_RST_TBURST 12'h010
`define SWG_MIDSCALE 10'h200
`define SWG_TIMER_MAX 12'hFFF

// ***************************************************************
// Host command port map and timing
// ***************************************************************
`define SWG_H_TX 4'h0
`define SWG_H_PINS 4'h4
`define SWG_H_STAT 4'h8
`define SWG_PIN_TRIG 0
`define SWG_PIN_ABORT 1
`define SWG_PIN_STBY 2
`define SWG_HALF_DIV 2

`endif

// ==== rtl/swg_pkg.sv ====
// Purpose: Types for the sweep generator pin control block
// Assumes: swg_defs.svh holds the numbers
// Notes: All state of the host and device modules is one of these structs
`include "swg_defs.svh"

package swg_pkg;

	// ***************************************************************
	// State encodings, Gray along idle, run, halt
	// ***************************************************************
	typedef enum logic [1:0] {SWG_IDLE = 2'b00, SWG_RUN = 2'b01,
		SWG_HALT = 2'b11} swg_sweep_t;

	typedef enum logic [1:0] {SWG_H_IDLE = 2'b00, SWG_H_SHIFT = 2'b01,
		SWG_H_DONE = 2'b11} swg_host_st_t;

	// ***************************************************************
	// Device state, master clock domain
	// ***************************************************************
	typedef struct packed {
		logic [1:0] trg_s;
		logic trg_p;
		logic [1:0] abt_s;
		logic abt_p;
		logic [1:0] stb_s;
		logic [1:0] tgl_s;
		logic tgl_p;
		logic [11:0] ctrl;
		logic [11:0] fstart;
		logic [11:0] fdelta;
		logic [11:0] nincr;
		logic [11:0] tint;
		logic [11:0] tburst;
		swg_sweep_t state;
		logic [15:0] freq;
		logic [11:0] step;
		logic [11:0] timer;
		logic [15:0] phase;
		logic [9:0] dac;
		logic stat_pls;
	} swg_dev_t;

	// ***************************************************************
	// Device state, serial clock domain
	// ***************************************************************
	typedef struct packed {
		logic [3:0] cnt;
		logic [14:0] shreg;
	} swg_lnk_cnt_t;

	typedef struct packed {
		logic [15:0] word;
		logic tgl;
	} swg_lnk_word_t;

	// ***************************************************************
	// Host state
	// ***************************************************************
	typedef struct packed {
		swg_host_st_t state;
		logic sclk;
		logic fsn;
		logic sdo;
		logic [7:0] half;
		logic [3:0] bitn;
		logic [15:0] sh;
		logic [2:0] pins;
		logic [1:0] st_s;
		logic [1:0] sb_s;
		logic [15:0] rdata;
	} swg_host_t;

endpackage : swg_pkg

// ==== rtl/swg_if.sv ====
// Purpose: Pin bundle between host and sweep generator
// Assumes: Host makes the serial clock from its own clock
// Notes: Enabled outputs carry their enables beside them
`timescale 1ns/10ps

interface swg_if;
	logic sclk;
	logic frame_select_n;
	logic serial_data_in;
	logic sweep_trigger;
	logic abort_in;
	logic standby_in;
	logic sweep_status_out;
	logic sweep_status_oe;
	logic sign_bit_out;
	logic sign_bit_oe;

	// ***************************************************************
	// One modport per party
	// ***************************************************************
	modport device (input sclk, input frame_select_n, input serial_data_in,
		input sweep_trigger, input abort_in, input standby_in,
		output sweep_status_out, output sweep_status_oe,
		output sign_bit_out, output sign_bit_oe);

	modport host (output sclk, output frame_select_n,
		output serial_data_in, output sweep_trigger, output abort_in,
		output standby_in, input sweep_status_out, input sweep_status_oe,
		input sign_bit_out, input sign_bit_oe);
endinterface : swg_if

// ==== rtl/swg_host.sv ====
// Purpose: Host end, sends serial words and drives control pins
// Assumes: Command port on REF_CLK, pins from the device are async
// Notes: Serial clock is a divided copy of REF_CLK, idles high
`timescale 1ns/10ps
`include "swg_defs.svh"

module swg_host #(
	parameter int HALF_DIV = `SWG_HALF_DIV
) (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	swg_if.host LNK,
	input wire logic [3:0] CMD_ADDR,
	input wire logic [15:0] CMD_WDATA,
	input wire logic CMD_WR,
	input wire logic CMD_RD,
	output logic [15:0] CMD_RDATA
);
	import swg_pkg::*;

	swg_host_t q;
	swg_host_t d;
	logic tick;

	// Half period of the serial clock elapsed
	assign tick = (q.half == 8'(HALF_DIV - 1));

	// ***************************************************************
	// Next state
	// ***************************************************************
	always_comb
	begin
		d = q;
		d.st_s = {q.st_s[0], LNK.sweep_status_out & LNK.sweep_status_oe};
		d.sb_s = {q.sb_s[0], LNK.sign_bit_out & LNK.sign_bit_oe};
		d.half = tick ? 8'h00 : q.half + 8'h01;
		d.rdata = 16'h0000;
		// Pins written directly; trigger and abort edges are software's
		if (CMD_WR && CMD_ADDR == `SWG_H_PINS)
			d.pins = CMD_WDATA[2:0];
		if (CMD_RD)
		begin
			unique case (CMD_ADDR)
				`SWG_H_TX: d.rdata = q.sh;
				`SWG_H_PINS: d.rdata = {13'h0000, q.pins};
				`SWG_H_STAT: d.rdata = {13'h0000, q.sb_s[1], q.st_s[1],
					q.state != SWG_H_IDLE};
				default: d.rdata = 16'h0000;
			endcase
		end
		unique case (q.state)
			SWG_H_IDLE:
			begin
				// A write while busy is dropped, so words never overlap
				if (CMD_WR && CMD_ADDR == `SWG_H_TX)
				begin
					d.fsn = 1'b0;
					d.sclk = 1'b1;
					d.sdo = CMD_WDATA[15];
					d.sh = CMD_WDATA;
					d.bitn = 4'h0;
					d.half = 8'h00;
					d.state = SWG_H_SHIFT;
				end
			end
			SWG_H_SHIFT:
			begin
				if (tick)
				begin
					if (q.sclk)
						d.sclk = 1'b0;
					else
					begin
						d.sclk = 1'b1;
						if (q.bitn == `SWG_LAST_BIT)
							d.state = SWG_H_DONE;
						else
						begin
							// Data changes on the rising edge, a half ahead
							d.bitn = q.bitn + 4'h1;
							d.sh = {q.sh[14:0], 1'b0};
							d.sdo = q.sh[14];
						end
					end
				end
			end
			SWG_H_DONE:
			begin
				if (tick)
				begin
					d.fsn = 1'b1;
					d.state = SWG_H_IDLE;
				end
			end
			default: d.state = SWG_H_IDLE;
		endcase
	end

	// ***************************************************************
	// State register
	// ***************************************************************
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			q <= '0;
			q.sclk <= 1'b1;
			q.fsn <= 1'b1;
		end
		else
			q <= d;
	end

	assign LNK.sclk = q.sclk;
	assign LNK.frame_select_n = q.fsn;
	assign LNK.serial_data_in = q.sdo;
	assign LNK.sweep_trigger = q.pins[`SWG_PIN_TRIG];
	assign LNK.abort_in = q.pins[`SWG_PIN_ABORT];
	assign LNK.standby_in = q.pins[`SWG_PIN_STBY];
	assign CMD_RDATA = q.rdata;

endmodule : swg_host

// ==== rtl/swg_device.sv ====
// Purpose: Sweep generator pin control, serial load and sweep sequencing
// Assumes: REF_CLK is the master clock, serial clock from the host
// Notes: DAC word is the top of the phase accumulator, no sine table
`timescale 1ns/10ps
`include "swg_defs.svh"

module swg_device (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	swg_if.device LNK,
	output logic [9:0] DAC_DATA,
	output logic POWER_DOWN
);
	import swg_pkg::*;

	swg_dev_t q;
	swg_dev_t d;
	swg_lnk_cnt_t lc_q;
	swg_lnk_cnt_t lc_d;
	swg_lnk_word_t lw_q;
	swg_lnk_word_t lw_d;
	logic lnk_clr;
	logic trg_rise;
	logic abt_rise;
	logic word_new;
	logic ext_inc;
	logic burst;
	logic [11:0] wdata;

	// ***************************************************************
	// Serial clock domain
	// ***************************************************************

	// Bit counter is cleared while the frame is idle, not by clock edges
	assign lnk_clr = SYS_RST | LNK.frame_select_n;

	// Shift on each falling edge, hand over the word after bit sixteen
	always_comb
	begin
		lc_d = lc_q;
		lw_d = lw_q;
		lc_d.cnt = lc_q.cnt + 4'h1;
		lc_d.shreg = {lc_q.shreg[13:0], LNK.serial_data_in};
		if (lc_q.cnt == `SWG_LAST_BIT)
		begin
			lw_d.word = {lc_q.shreg, LNK.serial_data_in};
			lw_d.tgl = ~lw_q.tgl;
		end
	end

	// Counter and shifter, restarted by each new frame
	always_ff @(negedge LNK.sclk or posedge lnk_clr)
	begin
		if (lnk_clr)
			lc_q <= '0;
		else
			lc_q <= lc_d;
	end

	// Completed word and its toggle survive the end of the frame
	always_ff @(negedge LNK.sclk or posedge SYS_RST)
	begin
		if (SYS_RST)
			lw_q <= '0;
		else
			lw_q <= lw_d;
	end

	// ***************************************************************
	// Master clock domain helpers
	// ***************************************************************

	// Edge found on the second sync flop against its last value
	assign trg_rise = q.trg_s[1] & ~q.trg_p;
	assign abt_rise = q.abt_s[1] & ~q.abt_p;
	// Word is stable by the time its toggle has passed two flops
	assign word_new = q.tgl_s[1] ^ q.tgl_p;
	assign wdata = lw_q.word[`SWG_DATA_HI:0];
	assign ext_inc = q.ctrl[`SWG_CTRL_EXT_INC];
	assign burst = q.ctrl[`SWG_CTRL_MODE];

	// ***************************************************************
	// Next state
	// ***************************************************************
	always_comb
	begin
		d = q;
		d.trg_s = {q.trg_s[0], LNK.sweep_trigger};
		d.abt_s = {q.abt_s[0], LNK.abort_in};
		d.stb_s = {q.stb_s[0], LNK.standby_in};
		d.tgl_s = {q.tgl_s[0], lw_q.tgl};
		d.trg_p = q.trg_s[1];
		d.abt_p = q.abt_s[1];
		d.tgl_p = q.tgl_s[1];
		d.stat_pls = 1'b0;
		// Standby freezes all sweep state; only the syncs keep running
		if (!q.stb_s[1])
		begin
			if (word_new)
			begin
				unique case (lw_q.word[`SWG_ADDR_HI:`SWG_ADDR_LO])
					`SWG_ADDR_CTRL: d.ctrl = wdata;
					`SWG_ADDR_FSTART: d.fstart = wdata;
					`SWG_ADDR_FDELTA: d.fdelta = wdata;
					`SWG_ADDR_NINCR: d.nincr = wdata;
					`SWG_ADDR_TINT: d.tint = wdata;
					`SWG_ADDR_TBURST: d.tburst = wdata;
					default: d.ctrl = q.ctrl;
				endcase
			end
			unique case (q.state)
				SWG_IDLE, SWG_HALT:
				begin
					d.dac = `SWG_MIDSCALE;
					if (trg_rise)
					begin
						d.state = SWG_RUN;
						d.freq = {4'h0, q.fstart};
						d.step = 12'h000;
						d.timer = 12'h000;
						d.phase = 16'h0000;
					end
				end
				SWG_RUN:
				begin
					// Phase advances by the frequency word each master clock
					d.phase = q.phase + q.freq;
					if (q.timer != `SWG_TIMER_MAX)
						d.timer = q.timer + 12'h001;
					// Burst holds midscale for the rest of the interval
					if (burst && q.timer >= q.tburst)
						d.dac = `SWG_MIDSCALE;
					else
						d.dac = q.phase[15:6];
					if (abt_rise)
					begin
						d.state = SWG_HALT;
						d.dac = `SWG_MIDSCALE;
						d.phase = 16'h0000;
					end
					else if (trg_rise && !ext_inc)
					begin
						// A new trigger in auto mode restarts the sweep
						d.freq = {4'h0, q.fstart};
						d.step = 12'h000;
						d.timer = 12'h000;
						d.phase = 16'h0000;
					end
					else if ((ext_inc && trg_rise) ||
						(!ext_inc && q.timer >= q.tint))
					begin
						d.timer = 12'h000;
						// Burst steps restart at zero phase, continuous do not
						if (burst)
							d.phase = 16'h0000;
						if (q.step == q.nincr)
						begin
							d.step = 12'h000;
							d.freq = {4'h0, q.fstart};
							d.stat_pls = 1'b1;
						end
						else
						begin
							d.step = q.step + 12'h001;
							d.freq = q.freq + {4'h0, q.fdelta};
							d.stat_pls = ~q.ctrl[`SWG_CTRL_SRC_SEL];
						end
					end
				end
				default: d.state = SWG_IDLE;
			endcase
		end
	end

	// ***************************************************************
	// State register
	// ***************************************************************
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			q <= '0;
			q.ctrl <= `SWG_RST_CTRL;
			q.fstart <= `SWG_RST_FSTART;
			q.fdelta <= `SWG_RST_FDELTA;
			q.nincr <= `SWG_RST_NINCR;
			q.tint <= `SWG_RST_TINT;
			q.tburst <= `SWG_RST_TBURST;
			q.dac <= `SWG_MIDSCALE;
		end
		else
			q <= d;
	end

	// ***************************************************************
	// Pin outputs
	// ***************************************************************

	// Enables gate the pins; a disabled pin is held low so it reads clean
	assign LNK.sweep_status_out = q.stat_pls & q.ctrl[`SWG_CTRL_STAT_OE];
	assign LNK.sweep_status_oe = q.ctrl[`SWG_CTRL_STAT_OE];
	assign LNK.sign_bit_out = ~q.dac[9] & q.ctrl[`SWG_CTRL_SIGN_OE];
	assign LNK.sign_bit_oe = q.ctrl[`SWG_CTRL_SIGN_OE];
	assign DAC_DATA = q.dac;
	assign POWER_DOWN = q.stb_s[1];

endmodule : swg_device

// ==== bench/swg_asserts.sv ====
// Purpose: Pin-level checks on the link between host and sweep generator
// Assumes: Every link signal is launched from REF_CLK
// Notes: Instantiated in tb_top beside the link, no bind
`timescale 1ns/10ps

module swg_asserts (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic sclk,
	input wire logic frame_select_n,
	input wire logic serial_data_in,
	input wire logic abort_in,
	input wire logic standby_in,
	input wire logic sweep_status_out,
	input wire logic sweep_status_oe,
	input wire logic sign_bit_out,
	input wire logic sign_bit_oe,
	input wire logic [9:0] DAC_DATA,
	input wire logic POWER_DOWN
);
	// ***************************************************************
	// Helper logic and properties
	// ***************************************************************
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	logic sclk_q;
	logic [4:0] falls_q;
	logic [4:0] falls_d;

	// Count serial clock falls inside a frame; idle frame clears it
	always_comb
	begin
		falls_d = falls_q;
		if (frame_select_n)
			falls_d = 5'h00;
		else if (sclk_q && !sclk)
			falls_d = falls_q + 5'h01;
	end

	// Registered copy, reset so a new run starts from zero
	always_ff @(posedge REF_CLK)
	begin
		sclk_q <= SYS_RST ? 1'b1 : sclk;
		falls_q <= SYS_RST ? 5'h00 : falls_d;
	end

	sequence s_abort_rise;
		!abort_in ##1 abort_in;
	endsequence
	sequence s_stby_rise;
		!standby_in ##1 standby_in;
	endsequence

	AST_STAT_GATED: assert property
		(!sweep_status_oe |-> !sweep_status_out)
		else $error("status pin driven while disabled");
	AST_SIGN_GATED: assert property
		(!sign_bit_oe |-> !sign_bit_out)
		else $error("sign pin driven while disabled");
	AST_SIGN_INV: assert property
		(sign_bit_oe |-> sign_bit_out == !DAC_DATA[9])
		else $error("sign pin is not the inverted DAC top bit");
	AST_STAT_PULSE: assert property
		(sweep_status_out |=> !sweep_status_out)
		else $error("status pulse longer than one cycle");
	AST_FRAME_START: assert property
		($fell(frame_select_n) |-> sclk)
		else $error("frame opened with serial clock low");
	AST_DATA_HOLD: assert property
		($fell(sclk) |-> $stable(serial_data_in))
		else $error("serial data moved at the sampling edge");
	AST_WORD_LEN: assert property
		($rose(frame_select_n) |-> falls_q == 5'h10)
		else $error("frame closed without sixteen bits");
	AST_ABORT_MID: assert property
		(s_abort_rise |-> ##[1:8] (DAC_DATA == 10'h200) [*8])
		else $error("abort did not park the DAC at midscale");
	AST_STBY: assert property
		(s_stby_rise |-> ##[1:5] POWER_DOWN)
		else $error("standby did not power down");
endmodule : swg_asserts

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench, host and device joined by the link
// Assumes: Host command port used as the register bus
// Notes: A second device is driven by raw bench frames for faults
`timescale 1ns/10ps
`include "swg_defs.svh"

module tb_top;
	import swg_pkg::*;
	// ***************************************************************
	// Clock, design and checker
	// ***************************************************************
	logic REF_CLK, SYS_RST, CMD_WR, CMD_RD, POWER_DOWN, pd2;
	logic [3:0] CMD_ADDR;
	logic [15:0] CMD_WDATA, CMD_RDATA, d;
	logic [9:0] DAC_DATA, dac2;
	int error_cnt = 0, checks = 0, pulses = 0, mids = 0;
	swg_if lnk();
	swg_if l2();
	swg_host swg_host_inst (.REF_CLK, .SYS_RST, .LNK(lnk), .CMD_ADDR,
		.CMD_WDATA, .CMD_WR, .CMD_RD, .CMD_RDATA);
	swg_device swg_device_inst (.REF_CLK, .SYS_RST, .LNK(lnk), .DAC_DATA,
		.POWER_DOWN);
	swg_device swg_device_inst2 (.REF_CLK, .SYS_RST, .LNK(l2),
		.DAC_DATA(dac2), .POWER_DOWN(pd2));
	swg_asserts swg_asserts_inst (.REF_CLK, .SYS_RST, .sclk(lnk.sclk),
		.frame_select_n(lnk.frame_select_n),
		.serial_data_in(lnk.serial_data_in), .abort_in(lnk.abort_in),
		.standby_in(lnk.standby_in), .sweep_status_out(lnk.sweep_status_out),
		.sweep_status_oe(lnk.sweep_status_oe),
		.sign_bit_out(lnk.sign_bit_out), .sign_bit_oe(lnk.sign_bit_oe),
		.DAC_DATA, .POWER_DOWN);

	initial
	begin
		REF_CLK = 1'b0;
		forever #20 REF_CLK = ~REF_CLK;
	end

	// Counted at the falling edge, half a cycle clear of the launching edge
	always @(negedge REF_CLK)
	begin
		if (lnk.sweep_status_out === 1'b1)
			pulses++;
		if (DAC_DATA === 10'h200)
			mids++;
	end

	// ***************************************************************
	// Tasks
	// ***************************************************************
	task automatic chk(input string nm, input logic [15:0] s, e);
		checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic cmd_wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge REF_CLK);
		CMD_ADDR <= a;
		CMD_WDATA <= v;
		CMD_WR <= 1'b1;
		@(posedge REF_CLK);
		CMD_WR <= 1'b0;
	endtask : cmd_wr

	task automatic cmd_rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge REF_CLK);
		CMD_ADDR <= a;
		CMD_RD <= 1'b1;
		@(posedge REF_CLK);
		CMD_RD <= 1'b0;
		@(negedge REF_CLK);
		v = CMD_RDATA;
	endtask : cmd_rd

	// Send one word, poll busy, then leave time for the domain crossing
	task automatic send(input logic [3:0] r, input logic [11:0] v);
		cmd_wr(`SWG_H_TX, {r, v});
		repeat (200)
		begin
			cmd_rd(`SWG_H_STAT, d);
			if (d[0] === 1'b0)
				break;
		end
		chk("busy", {15'h0, d[0]}, 16'h0000);
		repeat (8) @(posedge REF_CLK);
	endtask : send

	task automatic trig();
		cmd_wr(`SWG_H_PINS, 16'h0001);
		repeat (4) @(posedge REF_CLK);
		cmd_wr(`SWG_H_PINS, 16'h0000);
		repeat (6) @(posedge REF_CLK);
	endtask : trig

	// Raw frame of n bits on the second link; short n is a broken frame
	// Bench link clock has a 32 ns period, offset so it never meets REF_CLK
	task automatic raw(input logic [15:0] w, input int n);
		#7 l2.frame_select_n <= 1'b0;
		for (int i = 15; i > 15 - n; i--)
		begin
			l2.serial_data_in <= w[i];
			#16 l2.sclk <= 1'b0;
			#16 l2.sclk <= 1'b1;
		end
		#16 l2.frame_select_n <= 1'b1;
		l2.serial_data_in <= ~w[16 - n];
		repeat (10) @(posedge REF_CLK);
	endtask : raw

	task automatic finish_test();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	// ***************************************************************
	// Tests
	// ***************************************************************
	initial
	begin
		// Reset rises after time zero so the link flops see its edge
		#1;
		{CMD_WR, CMD_RD, CMD_ADDR, CMD_WDATA} = '0;
		{l2.sweep_trigger, l2.abort_in, l2.standby_in} = 3'h0;
		{l2.sclk, l2.frame_select_n, l2.serial_data_in} = 3'h6;
		SYS_RST = 1'b1;
		repeat (5) @(posedge REF_CLK);
		SYS_RST <= 1'b0;
		cmd_rd(4'hC, d);
		chk("unmapped", d, 16'h0000);
		chk("oe", 16'(lnk.sweep_status_oe), 16'h0000);
		send(`SWG_ADDR_CTRL, 12'h00D);
		chk("stat_oe", 16'(lnk.sweep_status_oe), 16'h0001);
		chk("sign_oe", 16'(lnk.sign_bit_oe), 16'h0001);
		trig();
		repeat (20) @(posedge REF_CLK);
		pulses = 0;
		repeat (3) trig();
		repeat (20) @(posedge REF_CLK);
		chk("ext_steps", 16'(pulses), 16'h0003);
		send(`SWG_ADDR_CTRL, 12'h00C);
		trig();
		pulses = 0;
		mids = 0;
		repeat (330) @(posedge REF_CLK);
		chk("auto_steps", 16'(pulses), 16'h000A);
		chk("cw_mid", 16'(mids < 20), 16'h0001);
		send(`SWG_ADDR_CTRL, 12'h00E);
		pulses = 0;
		repeat (330) @(posedge REF_CLK);
		chk("eos", 16'(pulses >= 1 && pulses <= 3), 16'h0001);
		send(`SWG_ADDR_CTRL, 12'h08C);
		mids = 0;
		repeat (200) @(posedge REF_CLK);
		chk("burst_mid", 16'(mids >= 60), 16'h0001);
		cmd_wr(`SWG_H_PINS, 16'h0002);
		cmd_rd(`SWG_H_PINS, d);
		chk("pins", d, 16'h0002);
		repeat (10) @(posedge REF_CLK);
		chk("abort", 16'(DAC_DATA), 16'h0200);
		mids = 0;
		repeat (100) @(posedge REF_CLK);
		chk("abort_hold", 16'(mids), 16'h0064);
		cmd_rd(`SWG_H_STAT, d);
		chk("stat_halt", d, 16'h0000);
		// Device reset ahead of standby gives the lowest standby draw
		SYS_RST <= 1'b1;
		repeat (5) @(posedge REF_CLK);
		SYS_RST <= 1'b0;
		chk("rst_dac", 16'(DAC_DATA), 16'h0200);
		cmd_wr(`SWG_H_PINS, 16'h0004);
		repeat (6) @(posedge REF_CLK);
		chk("stby", 16'(POWER_DOWN), 16'h0001);
		cmd_wr(`SWG_H_PINS, 16'h0000);
		repeat (6) @(posedge REF_CLK);
		chk("wake", 16'(POWER_DOWN), 16'h0000);
		raw(16'h0004, 12);
		chk("short", 16'(l2.sweep_status_oe), 16'h0000);
		raw(16'h0004, 16);
		chk("full", 16'(l2.sweep_status_oe), 16'h0001);
		chk("pd2", 16'(pd2), 16'h0000);
		chk("idle_mid", 16'(dac2), 16'h0200);
		finish_test();
	end

	// Whole run is under two thousand cycles; this limit only cuts a hang
	initial
	begin
		repeat (20000) @(posedge REF_CLK);
		error_cnt++;
		finish_test();
	end
endmodule : tb_top
